// File: hw/fdcr_regs.sv
/*
 Floppy controller host control/status register bank over AXI4-Lite.
 Assumes the controller engine supplies its status flags synchronously to core_clk.
*/
`default_nettype none
// What this block does
// R01: Write-only output register at index 2
// R02: Master reset clears output register
// R03: Bit 4 drives motor A enable
// R04: Bit 3 gates DMA and interrupt requests
// R05: Bit 2 low holds controller in reset
// R06: Bits 1:0 select drive A to D
// R07: Normal mode tape register only bits 1:0
// R08: Three-mode shows full eight-bit tape layout
// R09: Bits 7:6 copy media ID config
// R10: Bits 5:4 show selected drive type
// R11: Bits 3:2 copy boot drive config
// R12: Tape select assigns tape drive 1-3
// R13: Status bit 7 shows host request ready
// R14: Status bit 6 shows transfer direction
// R15: Bit 5 set only non-DMA execution
// R16: Bit 4 shows command in progress
// R17: Bits 3:0 show per-drive seek busy
// R18: Reserved bits read zero, writes ignored
module fdcr_regs (
   // Clock, reset, enable
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic clk_en,
   // AXI4-Lite slave
   input wire logic [5:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [5:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   // Controller engine status and requests
   input wire fdcr_pkg::fdcr_stat_s eng_stat,
   input wire logic eng_dma_req,
   input wire logic eng_int_req,
   // Drive and host side outputs
   output logic motor_a_en,
   output logic dma_req,
   output logic int_req,
   output logic ctrl_reset,
   output logic [1:0] drive_sel,
   output logic [1:0] tape_sel,
   output logic irq
);
   logic [7:0] dout_ff;
   logic [1:0] tape_ff;
   logic [16:0] cfg_ff;
   logic [2:0] ist_ff;
   logic [2:0] imask_ff;
   logic [7:0] mstat_ff;
   logic [1:0] last_sel_ff;
   logic aw_ff, w_ff;
   logic [3:0] awidx_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   fdcr_pkg::fdcr_stat_s prev_ff;

   // Write path: address and data are captured in either order
   wire logic aw_take = s_awvalid && s_awready;
   wire logic w_take = s_wvalid && s_wready;
   wire logic do_write = aw_ff && w_ff && !s_bvalid;
   wire logic wr_lane0 = wstrb_ff[0];
   wire logic wr_dout = do_write && awidx_ff == fdcr_pkg::IDX_DOUT && wr_lane0;
   wire logic wr_tape = do_write && awidx_ff == fdcr_pkg::IDX_TAPE && wr_lane0;
   wire logic wr_cfg = do_write && awidx_ff == fdcr_pkg::IDX_CFG;
   wire logic wr_ist = do_write && awidx_ff == fdcr_pkg::IDX_IRQ_STAT && wr_lane0;
   wire logic wr_imask = do_write && awidx_ff == fdcr_pkg::IDX_IRQ_MASK && wr_lane0;
   wire logic wr_hit = (awidx_ff == fdcr_pkg::IDX_DOUT) || (awidx_ff == fdcr_pkg::IDX_TAPE)
      || (awidx_ff == fdcr_pkg::IDX_CFG) || (awidx_ff == fdcr_pkg::IDX_IRQ_STAT)
      || (awidx_ff == fdcr_pkg::IDX_IRQ_MASK);

   // Tape register view depends on three-mode enable
   wire logic three_mode = cfg_ff[0];
   wire logic [7:0] media_boot = cfg_ff[8:1];
   wire logic [7:0] drv_type = cfg_ff[16:9];
   wire logic [1:0] type_sel = drv_type[2*last_sel_ff +: 2]; // R10
   wire logic [7:0] tape_full = {media_boot[5:4], // R09
      type_sel, media_boot[7:6], tape_ff}; // R08 R11 R12
   wire logic [7:0] tape_view = three_mode ? tape_full : {6'h00, tape_ff}; // R07 R18

   // Read decode
   wire logic [3:0] ridx = fdcr_pkg::fdcr_idx(s_araddr);
   wire logic rd_hit = (ridx == fdcr_pkg::IDX_TAPE) || (ridx == fdcr_pkg::IDX_MSTAT)
      || (ridx == fdcr_pkg::IDX_CFG) || (ridx == fdcr_pkg::IDX_IRQ_STAT)
      || (ridx == fdcr_pkg::IDX_IRQ_MASK);
   wire logic [31:0] rd_mux =
      (ridx == fdcr_pkg::IDX_TAPE) ? {24'h000000, tape_view} :
      (ridx == fdcr_pkg::IDX_MSTAT) ? {24'h000000, mstat_ff} :
      (ridx == fdcr_pkg::IDX_CFG) ? {15'h0000, cfg_ff} :
      (ridx == fdcr_pkg::IDX_IRQ_STAT) ? {29'h00000000, ist_ff} :
      (ridx == fdcr_pkg::IDX_IRQ_MASK) ? {29'h00000000, imask_ff} : 32'h00000000;

   // Status assembly; controller reset holds engine-derived status idle
   wire logic run = dout_ff[fdcr_pkg::DOUT_CTRL_RUN];
   wire logic [7:0] nxt_mstat = run ? {eng_stat.host_request_ready, // R13
      eng_stat.transfer_direction, // R14
      eng_stat.non_dma_exec, // R15
      eng_stat.command_in_progress, // R16
      eng_stat.seek_busy} : 8'h00; // R17 R05

   // Events: ready rise, any seek finishing, command finishing
   wire logic [2:0] ev;
   assign ev[fdcr_pkg::EV_REQ_READY] = eng_stat.host_request_ready
      && !prev_ff.host_request_ready;
   assign ev[fdcr_pkg::EV_SEEK_DONE] = |(prev_ff.seek_busy & ~eng_stat.seek_busy);
   assign ev[fdcr_pkg::EV_CMD_DONE] = prev_ff.command_in_progress
      && !eng_stat.command_in_progress;
   wire logic [2:0] ist_clr = wr_ist ? wdata_ff[2:0] : 3'h0;
   // Set wins over a simultaneous clear
   wire logic [2:0] nxt_ist = (ist_ff & ~ist_clr) | (run ? ev : 3'h0);

   // Write channel handshake
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         aw_ff <= 1'b0;
         w_ff <= 1'b0;
         awidx_ff <= 4'h0;
         wdata_ff <= 32'h00000000;
         wstrb_ff <= 4'h0;
         s_awready <= 1'b0;
         s_wready <= 1'b0;
         s_bvalid <= 1'b0;
         s_bresp <= fdcr_pkg::RESP_OKAY;
      end else if (clk_en) begin
         s_awready <= !aw_ff && !aw_take && !s_bvalid;
         s_wready <= !w_ff && !w_take && !s_bvalid;
         if (aw_take) begin
            aw_ff <= 1'b1;
            awidx_ff <= fdcr_pkg::fdcr_idx(s_awaddr);
         end
         if (w_take) begin
            w_ff <= 1'b1;
            wdata_ff <= s_wdata;
            wstrb_ff <= s_wstrb;
         end
         if (do_write) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            s_bvalid <= 1'b1;
            s_bresp <= wr_hit ? fdcr_pkg::RESP_OKAY : fdcr_pkg::RESP_SLVERR;
         end else if (s_bvalid && s_bready) begin
            s_bvalid <= 1'b0;
         end
      end
   end

   // Read channel
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         s_arready <= 1'b0;
         s_rvalid <= 1'b0;
         s_rdata <= 32'h00000000;
         s_rresp <= fdcr_pkg::RESP_OKAY;
      end else if (clk_en) begin
         s_arready <= !s_rvalid && !(s_arvalid && s_arready);
         if (s_arvalid && s_arready) begin
            s_rvalid <= 1'b1;
            s_rdata <= rd_mux;
            s_rresp <= rd_hit ? fdcr_pkg::RESP_OKAY : fdcr_pkg::RESP_SLVERR;
         end else if (s_rvalid && s_rready) begin
            s_rvalid <= 1'b0;
         end
      end
   end

   // Control registers
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         dout_ff <= fdcr_pkg::DOUT_RST; // R02
         tape_ff <= fdcr_pkg::TAPE_RST;
         cfg_ff <= fdcr_pkg::CFG_RST;
         imask_ff <= fdcr_pkg::IMASK_RST;
         last_sel_ff <= 2'h0;
      end else if (clk_en) begin
         if (wr_dout) begin
            dout_ff <= {3'h0, s_wdata_hold(wdata_ff)}; // R01 R18
            last_sel_ff <= wdata_ff[1:0];
         end
         if (wr_tape)
            tape_ff <= wdata_ff[1:0]; // R12
         if (wr_cfg)
            cfg_ff <= wdata_ff[16:0];
         if (wr_imask)
            imask_ff <= wdata_ff[2:0];
      end
   end

   function automatic logic [4:0] s_wdata_hold(input logic [31:0] d);
      s_wdata_hold = d[4:0];
   endfunction

   // Status, interrupts and pin outputs
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         mstat_ff <= 8'h00; // R13
         prev_ff <= '0;
         ist_ff <= 3'h0;
         irq <= 1'b0;
         motor_a_en <= 1'b0;
         dma_req <= 1'b0;
         int_req <= 1'b0;
         ctrl_reset <= 1'b1;
         drive_sel <= 2'h0;
         tape_sel <= 2'h0;
      end else if (clk_en) begin
         mstat_ff <= nxt_mstat;
         prev_ff <= eng_stat;
         ist_ff <= nxt_ist;
         irq <= |(nxt_ist & imask_ff);
         motor_a_en <= dout_ff[fdcr_pkg::DOUT_MOTOR_A]; // R03
         dma_req <= eng_dma_req && dout_ff[fdcr_pkg::DOUT_DMA_INT] && run; // R04
         int_req <= eng_int_req && dout_ff[fdcr_pkg::DOUT_DMA_INT] && run; // R04
         ctrl_reset <= !run; // R05
         drive_sel <= dout_ff[1:0]; // R06
         tape_sel <= tape_ff;
      end
   end
endmodule // fdcr_regs
`default_nettype wire

// File: hw/fdcr_pkg.sv
/*
 Package for the floppy host control and status register bank.
 Assumes a 32-bit AXI4-Lite register bus and one core clock.
*/
`default_nettype none
package fdcr_pkg;
   // Register byte addresses (printed offsets are indices, byte address is four times)
   localparam logic [3:0] IDX_DOUT = 4'h2;
   localparam logic [3:0] IDX_TAPE = 4'h3;
   localparam logic [3:0] IDX_MSTAT = 4'h4;
   localparam logic [3:0] IDX_CFG = 4'h8;
   localparam logic [3:0] IDX_IRQ_STAT = 4'h9;
   localparam logic [3:0] IDX_IRQ_MASK = 4'hA;
   localparam logic [7:0] DOUT_RST = 8'h00;
   localparam logic [1:0] TAPE_RST = 2'h0;
   // Drive type fields come up as all ones, the rest of the config word as zero
   localparam logic [16:0] CFG_RST = 17'h1FE00;
   localparam logic [2:0] IMASK_RST = 3'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Field positions of the digital output register
   localparam int DOUT_MOTOR_A = 4;
   localparam int DOUT_DMA_INT = 3;
   localparam int DOUT_CTRL_RUN = 2;
   // Interrupt event bits
   localparam int EV_REQ_READY = 0;
   localparam int EV_SEEK_DONE = 1;
   localparam int EV_CMD_DONE = 2;

   typedef struct packed {
      logic host_request_ready;
      logic transfer_direction;
      logic non_dma_exec;
      logic command_in_progress;
      logic [3:0] seek_busy;
   } fdcr_stat_s;

   typedef struct packed {
      logic [7:0] drive_type_config;
      logic [7:0] media_boot_config;
      logic three_mode_enable;
   } fdcr_cfg_s;

   function automatic logic [3:0] fdcr_idx(input logic [5:0] addr);
      fdcr_idx = addr[5:2];
   endfunction
endpackage
`default_nettype wire

// File: sim/fdcr_regs_chk.sv
/* Port checker for fdcr_regs.
 Assumes clk_en is held high. */
`default_nettype none
module fdcr_regs_chk (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Register bus
   input wire logic [5:0] s_awaddr,
   input wire logic s_awvalid,
   input wire logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic s_wvalid,
   input wire logic s_wready,
   input wire logic [5:0] s_araddr,
   input wire logic s_arvalid,
   input wire logic s_arready,
   input wire logic [31:0] s_rdata,
   input wire logic [1:0] s_rresp,
   input wire logic s_rvalid,
   // Engine and drive side
   input wire logic eng_dma_req,
   input wire logic eng_int_req,
   input wire logic motor_a_en,
   input wire logic dma_req,
   input wire logic int_req,
   input wire logic ctrl_reset,
   input wire logic [1:0] drive_sel,
   input wire logic irq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   property p_dout;
      logic [4:0] d;
      (s_awvalid && s_awready && s_awaddr == 6'h08 && s_wvalid && s_wready, d = s_wdata[4:0])
         |-> ##3 {motor_a_en, !ctrl_reset, drive_sel} == {d[4], d[2], d[1:0]};
   endproperty
   chk_reset_outs: assert property ($rose(rstn) |-> ctrl_reset && !motor_a_en && !irq)
      else $error("outputs not cleared");
   chk_dout_apply: assert property (p_dout)
      else $error("output fields not applied");
   // The request outputs and the reset flag are both registered from run in the same cycle
   chk_hold_gate: assert property (ctrl_reset [*2] |-> !dma_req && !int_req)
      else $error("requests pass in reset");
   chk_dma_gate: assert property (dma_req |-> $past(eng_dma_req))
      else $error("dma request without cause");
   chk_int_gate: assert property (int_req |-> $past(eng_int_req))
      else $error("int request without cause");
   chk_wo_read: assert property (s_arvalid && s_arready && s_araddr == 6'h08
      |=> s_rvalid && s_rresp == 2'h2)
      else $error("output register readable");
   chk_rd_upper: assert property (s_rvalid |-> s_rdata[31:17] == 15'h0000)
      else $error("upper read bits set");
   chk_rd_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
      else $error("read answer late");
   cover property (irq);
   cover property (dma_req && int_req);
   cover property (motor_a_en && drive_sel == 2'h3);
endmodule // fdcr_regs_chk
bind fdcr_regs fdcr_regs_chk u_fdcr_regs_chk (.*);
`default_nettype wire

// File: sim/fdcr_eng_model.sv
/* Engine stand-in: status levels and seek flags.
 Assumes commands change just after a clock edge. */
`default_nettype none
module fdcr_eng_model (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Bench commands
   input wire logic [7:0] stat_set,
   input wire logic [3:0] seek_go,
   // Engine status
   output var fdcr_pkg::fdcr_stat_s eng_stat
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] busy_ff;
   // Seek flags are registered, so they lag the command by a cycle
   always_ff @(posedge core_clk) busy_ff <= rstn ? seek_go : 4'h0;
   assign eng_stat = {stat_set[7:4], busy_ff};
endmodule // fdcr_eng_model
`default_nettype wire

// File: sim/fdcr_regs_tb.sv
/* Bench for fdcr_regs: bus tasks, random and corner tests.
 Assumes the checker is bound to the design. */
`default_nettype none
module fdcr_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0, rstn = 1'b0, clk_en = 1'b1;
   logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
   logic [5:0] s_awaddr = 6'h00, s_araddr = 6'h00;
   logic [3:0] s_wstrb = 4'hF, seek_go = 4'h0;
   logic [31:0] s_wdata = 32'h0, v, d;
   logic eng_dma_req = 1'b0, eng_int_req = 1'b0;
   logic [7:0] stat_set = 8'h00;
   logic [1:0] rs, ts;
   wire logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, motor_a_en, dma_req, int_req;
   wire logic ctrl_reset, irq;
   wire logic [1:0] s_bresp, s_rresp, drive_sel, tape_sel;
   wire logic [31:0] s_rdata;
   wire fdcr_pkg::fdcr_stat_s eng_stat;
   int errors = 0, check_count = 0, cyc = 0;
   fdcr_regs u_fdcr_regs (.*);
   fdcr_eng_model u_fdcr_eng_model (.*);
   initial forever #4 core_clk = ~core_clk;
   task automatic wrap_up();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         errors = errors + 1;
         wrap_up();
      end
   end
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         errors++;
         $display("[ERR] %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] dw, input logic [1:0] er);
      logic ta, tw;
      ta = 1'b0;
      tw = 1'b0;
      @(posedge core_clk);
      s_awaddr <= a;
      s_wdata <= dw;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      while (!(ta && tw)) begin
         @(posedge core_clk);
         ta |= s_awready;
         tw |= s_wready;
         if (ta) s_awvalid <= 1'b0;
         if (tw) s_wvalid <= 1'b0;
      end
      do @(posedge core_clk); while (!s_bvalid);
      s_bready <= 1'b0;
      chk("bresp", s_bresp, er);
   endtask
   task automatic rd(input logic [5:0] a);
      @(posedge core_clk);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      do @(posedge core_clk); while (!s_arready);
      s_arvalid <= 1'b0;
      do @(posedge core_clk); while (!s_rvalid);
      v = s_rdata;
      rs = s_rresp;
      s_rready <= 1'b0;
   endtask
   // Tape word: config bit0 mode, bits 8:1 media and boot, bits 16:9 drive types
   function automatic logic [31:0] exp_tape(input logic [16:0] c, input logic [1:0] ds, t);
      if (!c[0]) return {30'h0, t};
      return {24'h0, c[6:5], c[9 + 2 * ds +: 2], c[8:7], t};
   endfunction
   initial begin
      v = $urandom(32'h1550);
      repeat (20) @(posedge core_clk);
      rstn <= 1'b1;
      rd(6'h0C);
      chk("tape_rst", v, 32'h0);
      chk("ctl_rst", ctrl_reset, 1'b1);
      rd(6'h08);
      chk("dout_rd", rs, 2'h2);
      rd(6'h3C);
      chk("unmapped", rs, 2'h2);
      $display("test reset done");
      for (int i = 0; i < 12; i++) begin
         d = $urandom & 32'h1FFFF;
         d[0] = i[2] | i[3];
         ts = $urandom;
         v = ($urandom & 32'hF0) | 32'h0C | i[1:0];
         wr(6'h08, v, 2'h0);
         wr(6'h20, d, 2'h0);
         wr(6'h0C, ts, 2'h0);
         chk("motor", motor_a_en, v[4]);
         chk("drv_sel", drive_sel, i[1:0]);
         chk("run", ctrl_reset, 1'b0);
         rd(6'h0C);
         chk("tape", v, exp_tape(d, i[1:0], ts));
         chk("tape_sel", tape_sel, ts);
      end
      $display("test output and tape done");
      eng_dma_req <= 1'b1;
      eng_int_req <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk("dma_on", {dma_req, int_req}, 2'h3);
      wr(6'h08, 32'h04, 2'h0);
      repeat (2) @(posedge core_clk);
      chk("dma_off", {dma_req, int_req}, 2'h0);
      for (int k = 0; k < 4; k++) begin
         stat_set <= $urandom;
         seek_go <= $urandom;
         repeat (3) @(posedge core_clk);
         rd(6'h10);
         chk("status", v, {stat_set[7:4], seek_go});
      end
      wr(6'h10, 32'h0, 2'h2);
      seek_go <= 4'h1;
      repeat (3) @(posedge core_clk);
      seek_go <= 4'h0;
      wr(6'h28, 32'h0, 2'h0);
      repeat (2) @(posedge core_clk);
      chk("irq_mask", irq, 1'b0);
      wr(6'h28, 32'h2, 2'h0);
      repeat (2) @(posedge core_clk);
      chk("irq_set", irq, 1'b1);
      wr(6'h24, 32'h2, 2'h0);
      repeat (2) @(posedge core_clk);
      chk("irq_clr", irq, 1'b0);
      wr(6'h08, 32'h00, 2'h0);
      repeat (2) @(posedge core_clk);
      chk("ctl_hold", ctrl_reset, 1'b1);
      $display("test engine and irq done");
      wr(6'h08, 32'h10, 2'h0);
      repeat (2) @(posedge core_clk);
      chk("motor_on", motor_a_en, 1'b1);
      rstn <= 1'b0;
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      rd(6'h0C);
      chk("tape_rst2", v, 32'h0);
      chk("motor_rst2", motor_a_en, 1'b0);
      chk("ctl_rst2", ctrl_reset, 1'b1);
      $display("test mid-run reset done");
      wrap_up();
   end
endmodule // fdcr_regs_tb
`default_nettype wire
